// >>> touch_ctrl_limits_gpio_timing.sv
`timescale 1ns/10ps
`include "touch_ctrl_defs.svh"

module touch_ctrl_limits_gpio_timing #(
  parameter logic [15:0] PART_CODE       = 16'h0a5c,
  parameter int          FCD_UNIT_CYCLES = 200,
  parameter int          TMR_UNIT_CYCLES = 7372
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic        res_valid_in,
  input  wire logic [2:0]  res_chan_in,
  input  wire logic [15:0] res_data_in,
  input  wire logic        seq_start_in,
  output logic             conv_start_out,
  output logic      [2:0]  conv_chan_out,
  output logic             seq_busy_out,
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe_out,
  output logic             alarm_n_out
);

  if (FCD_UNIT_CYCLES < 1 || TMR_UNIT_CYCLES < 0) begin : g_bad_unit
    $error("bad timing unit");
  end

  logic [15:0] ctrl1_r;
  logic [15:0] ctrl2_r;
  logic [15:0] ctrl3_r;
  logic [15:0] spare_r;
  logic [15:0] ab_high_r;
  logic [15:0] ab_low_r;
  logic [15:0] tp_high_r;
  logic [15:0] tp_low_r;
  logic [15:0] res_r [6];
  logic        pin_meta_r;
  logic        pin_sync_r;
  logic        pin_act;
  logic        ab_res;
  logic        tp_res;
  logic        ab_hi_hit;
  logic        ab_lo_hit;
  logic        tp_hi_hit;
  logic        tp_lo_hit;
  logic        wr_c3;
  logic        pin_alarm;
  logic        limit_alarm;
  logic [2:0]  res_idx;

  assign wr_c3   = reg_wr_in && reg_addr_in == `OFS_CTRL3;
  assign pin_act = ctrl2_r[`C2_PIN_EN] && ctrl2_r[`C2_PIN_DIR];
  assign ab_res  = res_valid_in && (res_chan_in == `CH_AUX || res_chan_in == `CH_BAT);
  assign tp_res  = res_valid_in && res_chan_in == `CH_TEMP;
  assign ab_hi_hit = ab_res && res_data_in > ab_high_r;
  assign ab_lo_hit = ab_res && res_data_in < ab_low_r;
  assign tp_hi_hit = tp_res && res_data_in > tp_high_r;
  assign tp_lo_hit = tp_res && res_data_in < tp_low_r;

  // Pin synchroniser
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ctrl1_r   <= `RST_ZERO;
      spare_r   <= `RST_ZERO;
      ab_high_r <= `RST_ZERO;
      ab_low_r  <= `RST_ZERO;
      tp_high_r <= `RST_ZERO;
      tp_low_r  <= `RST_ZERO;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `OFS_UNUSED:    spare_r   <= reg_wdata_in;
        `OFS_CTRL1:     ctrl1_r   <= reg_wdata_in;
        `OFS_AB_HIGH:   ab_high_r <= reg_wdata_in;
        `OFS_AB_LOW:    ab_low_r  <= reg_wdata_in;
        `OFS_TEMP_HIGH: tp_high_r <= reg_wdata_in;
        `OFS_TEMP_LOW:  tp_low_r  <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ctrl2_r <= `RST_CTRL2;
    end else begin
      if (reg_wr_in && reg_addr_in == `OFS_CTRL2) begin
        ctrl2_r <= reg_wdata_in;
      end
      if (pin_act) begin
        ctrl2_r[`C2_PIN_DATA] <= pin_sync_r ^ ~ctrl2_r[`C2_PIN_POL];
      end
    end
  end

  // Sticky limit status, set wins over clear
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ctrl3_r <= `RST_ZERO;
    end else begin
      if (wr_c3) begin
        ctrl3_r <= reg_wdata_in;
      end
      if (ab_hi_hit) begin
        ctrl3_r[`C3_AB_HI_STAT] <= 1'b1;
      end
      if (ab_lo_hit) begin
        ctrl3_r[`C3_AB_LO_STAT] <= 1'b1;
      end
      if (tp_hi_hit) begin
        ctrl3_r[`C3_TP_HI_STAT] <= 1'b1;
      end
      if (tp_lo_hit) begin
        ctrl3_r[`C3_TP_LO_STAT] <= 1'b1;
      end
    end
  end

  // Result index from channel code
  always_comb begin
    case (res_chan_in)
      `CH_X:    res_idx = 3'h0;
      `CH_Y:    res_idx = 3'h1;
      `CH_Z1:   res_idx = 3'h2;
      `CH_Z2:   res_idx = 3'h3;
      `CH_AUX:  res_idx = 3'h4;
      `CH_BAT:  res_idx = 3'h4;
      `CH_TEMP: res_idx = 3'h5;
      default:  res_idx = 3'h7;
    endcase
  end

  // Results written only by the converter
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 6; i++) begin
        res_r[i] <= `RST_ZERO;
      end
    end else if (res_valid_in && res_idx != 3'h7) begin
      res_r[res_idx] <= res_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= `RST_ZERO;
    end else begin
      case (reg_addr_in)
        `OFS_UNUSED:    reg_rdata_out <= spare_r;
        `OFS_CTRL1:     reg_rdata_out <= ctrl1_r;
        `OFS_CTRL2:     reg_rdata_out <= ctrl2_r;
        `OFS_CTRL3:     reg_rdata_out <= ctrl3_r;
        `OFS_AB_HIGH:   reg_rdata_out <= ab_high_r;
        `OFS_AB_LOW:    reg_rdata_out <= ab_low_r;
        `OFS_TEMP_HIGH: reg_rdata_out <= tp_high_r;
        `OFS_TEMP_LOW:  reg_rdata_out <= tp_low_r;
        `OFS_ID:        reg_rdata_out <= PART_CODE;
        default: begin
          if (reg_addr_in >= `OFS_RES_FIRST && reg_addr_in <= `OFS_RES_LAST) begin
            reg_rdata_out <= res_r[reg_addr_in[2:0]];
          end else begin
            reg_rdata_out <= `RST_ZERO;
          end
        end
      endcase
    end
  end

  assign pin_oe_out = ctrl2_r[`C2_PIN_EN] && !ctrl2_r[`C2_PIN_DIR];
  assign pin_out    = ctrl2_r[`C2_PIN_EN] && (ctrl2_r[`C2_PIN_DATA] ^ ~ctrl2_r[`C2_PIN_POL]);

  // Clears via pin data, enable, direction or mask
  assign pin_alarm = pin_act && ctrl2_r[`C2_PIN_DATA] && !ctrl3_r[`C3_PIN_MASK];
  assign limit_alarm = (ctrl3_r[`C3_AB_HI_STAT] && ctrl3_r[`C3_AB_HI_EN])
                    || (ctrl3_r[`C3_AB_LO_STAT] && ctrl3_r[`C3_AB_LO_EN])
                    || ((ctrl3_r[`C3_TP_HI_STAT] || ctrl3_r[`C3_TP_LO_STAT]) && ctrl3_r[`C3_TP_EN]);
  assign alarm_n_out = !(ctrl1_r[`C1_INT_EN] && (limit_alarm || pin_alarm));

  // Conversion sequencer
  touch_ctrl_pkg::seq_state_t state_r;
  logic [31:0] cnt_r;
  logic [4:0]  meas_left_r;
  logic [2:0]  idx_r;
  logic [2:0]  idx_code;
  logic [31:0] fcd_cyc;
  logic [31:0] tmr_cyc;
  logic [31:0] meas_cyc;
  logic [15:0] acq_cyc;
  logic [4:0]  med_n;
  logic        any_screen;
  logic        idx_sel;

  assign any_screen = |ctrl3_r[`C3_SEQ_LO + 3:`C3_SEQ_LO];
  assign idx_sel    = ctrl3_r[`C3_SEQ_LO + 32'(idx_r)];
  assign fcd_cyc    = 32'(ctrl2_r[`C2_FCD_HI:`C2_FCD_LO] + 2'd0) * 32'(FCD_UNIT_CYCLES) + 32'(FCD_UNIT_CYCLES);
  assign tmr_cyc    = 32'(ctrl1_r[`C1_TMR_HI:`C1_TMR_LO]) * 32'(TMR_UNIT_CYCLES);

  always_comb begin
    case (idx_r)
      3'h0:    idx_code = `CH_X;
      3'h1:    idx_code = `CH_Y;
      3'h2:    idx_code = `CH_Z1;
      3'h3:    idx_code = `CH_Z2;
      3'h4:    idx_code = (ctrl1_r[`C1_CHAN_HI:`C1_CHAN_LO] == `CH_BAT) ? `CH_BAT : `CH_AUX;
      default: idx_code = `CH_TEMP;
    endcase
  end

  // Measurements per channel from median setting
  always_comb begin
    case (ctrl2_r[`C2_MED_HI:`C2_MED_LO])
      2'h1:    med_n = 5'd4;
      2'h2:    med_n = 5'd8;
      2'h3:    med_n = 5'd16;
      default: med_n = 5'd1;
    endcase
  end

  always_comb begin
    case (ctrl1_r[`C1_ACQ_HI:`C1_ACQ_LO])
      2'h0:    acq_cyc = 16'(`ACQ2_CYC);
      2'h1:    acq_cyc = 16'(`ACQ4_CYC);
      2'h2:    acq_cyc = 16'(`ACQ8_CYC);
      default: acq_cyc = 16'(`ACQ16_CYC);
    endcase
    if (idx_r == 3'h5) begin
      acq_cyc = 16'(`ACQ16_CYC);
    end
  end

  assign meas_cyc = 32'(acq_cyc) + 32'(`CONV_CYC)
                  + ((ctrl2_r[`C2_MED_HI:`C2_MED_LO] != 2'h0) ? 32'(`SORT_CYC) : 32'd0);

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_r     <= touch_ctrl_pkg::S_IDLE;
      cnt_r       <= 32'd0;
      meas_left_r <= 5'd0;
      idx_r       <= 3'd0;
    end else begin
      if (cnt_r != 32'd0) begin
        cnt_r <= cnt_r - 32'd1;
      end
      case (state_r)
        touch_ctrl_pkg::S_IDLE: begin
          if (seq_start_in) begin
            idx_r <= 3'd0;
            if (any_screen) begin
              state_r <= touch_ctrl_pkg::S_PICK;
            end else begin
              cnt_r   <= fcd_cyc;
              state_r <= touch_ctrl_pkg::S_LEAD;
            end
          end
        end
        touch_ctrl_pkg::S_LEAD: begin
          if (cnt_r <= 32'd1) begin
            state_r <= touch_ctrl_pkg::S_PICK;
          end
        end
        touch_ctrl_pkg::S_PICK: begin
          if (idx_r > 3'd5) begin
            cnt_r   <= fcd_cyc;
            state_r <= touch_ctrl_pkg::S_TAIL;
          end else if (!idx_sel) begin
            idx_r <= idx_r + 3'd1;
          end else if (idx_r < 3'd4) begin
            cnt_r   <= fcd_cyc;
            state_r <= touch_ctrl_pkg::S_SETTLE;
          end else begin
            cnt_r       <= meas_cyc;
            meas_left_r <= med_n;
            state_r     <= touch_ctrl_pkg::S_MEAS;
          end
        end
        touch_ctrl_pkg::S_SETTLE: begin
          if (cnt_r <= 32'd1) begin
            cnt_r       <= meas_cyc;
            meas_left_r <= med_n;
            state_r     <= touch_ctrl_pkg::S_MEAS;
          end
        end
        touch_ctrl_pkg::S_MEAS: begin
          if (cnt_r <= 32'd1) begin
            if (meas_left_r <= 5'd1) begin
              idx_r   <= idx_r + 3'd1;
              state_r <= touch_ctrl_pkg::S_PICK;
            end else begin
              meas_left_r <= meas_left_r - 5'd1;
              cnt_r       <= meas_cyc;
            end
          end
        end
        touch_ctrl_pkg::S_TAIL: begin
          if (cnt_r <= 32'd1) begin
            cnt_r   <= tmr_cyc;
            state_r <= touch_ctrl_pkg::S_TIMER;
          end
        end
        touch_ctrl_pkg::S_TIMER: begin
          if (cnt_r <= 32'd1) begin
            idx_r   <= 3'd0;
            state_r <= (ctrl1_r[`C1_MODE_HI:`C1_MODE_LO] == `MODE_MASTER) ?
                       touch_ctrl_pkg::S_PICK : touch_ctrl_pkg::S_IDLE;
          end
        end
        default: state_r <= touch_ctrl_pkg::S_IDLE;
      endcase
    end
  end

  // Measurement start strobe
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      conv_start_out <= 1'b0;
      conv_chan_out  <= 3'd0;
    end else begin
      conv_start_out <= (state_r != touch_ctrl_pkg::S_MEAS && state_r != touch_ctrl_pkg::S_IDLE
                         && cnt_r <= 32'd1 && idx_r <= 3'd5 && idx_sel
                         && (state_r == touch_ctrl_pkg::S_SETTLE || idx_r >= 3'd4)
                         && state_r != touch_ctrl_pkg::S_TAIL && state_r != touch_ctrl_pkg::S_TIMER
                         && state_r != touch_ctrl_pkg::S_LEAD)
                     || (state_r == touch_ctrl_pkg::S_MEAS && cnt_r <= 32'd1 && meas_left_r > 5'd1);
      conv_chan_out  <= idx_code;
    end
  end

  assign seq_busy_out = state_r != touch_ctrl_pkg::S_IDLE;

  a_ab_high_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ab_res && res_data_in > ab_high_r |=> ctrl3_r[`C3_AB_HI_STAT])
    else $error("aux high status not set");
  a_ab_low_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ab_res && res_data_in < ab_low_r |=> ctrl3_r[`C3_AB_LO_STAT])
    else $error("aux low status not set");
  a_limit_equal_ok: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ab_res && res_data_in == ab_high_r && !wr_c3 && !ctrl3_r[`C3_AB_HI_STAT] |=> !ctrl3_r[`C3_AB_HI_STAT])
    else $error("equal result flagged high");
  a_alarm_from_limit: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ctrl1_r[`C1_INT_EN] && ctrl3_r[`C3_AB_HI_STAT] && ctrl3_r[`C3_AB_HI_EN] |-> !alarm_n_out)
    else $error("alarm missing on limit");
  a_pin_mask_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ctrl3_r[`C3_PIN_MASK] && !limit_alarm |-> alarm_n_out)
    else $error("masked pin raised alarm");
  a_pin_input_track: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pin_act && $stable(pin_act) && $stable(ctrl2_r[`C2_PIN_POL]) ##1 pin_act
    |-> ctrl2_r[`C2_PIN_DATA] == ($past(pin_sync_r) ^ ~$past(ctrl2_r[`C2_PIN_POL])))
    else $error("input data bit not tracking pin");
  a_pin_disabled: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !ctrl2_r[`C2_PIN_EN] |-> !pin_oe_out && alarm_n_out == !(ctrl1_r[`C1_INT_EN] && limit_alarm))
    else $error("disabled pin active");
  a_reset_ctrl2: assert property (@(posedge clk_in)
    !nrst_in |=> ctrl2_r == `RST_CTRL2 && ctrl3_r == `RST_ZERO)
    else $error("reset value wrong");
  a_tail_delay: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state_r == touch_ctrl_pkg::S_PICK && idx_r > 3'd5 |=> state_r == touch_ctrl_pkg::S_TAIL && cnt_r == fcd_cyc)
    else $error("closing delay missing");
  a_temp_acq: assert property (@(posedge clk_in) disable iff (!nrst_in)
    idx_r == 3'h5 |-> acq_cyc == 16'(`ACQ16_CYC))
    else $error("temperature acquisition not fixed");

endmodule : touch_ctrl_limits_gpio_timing

// >>> touch_ctrl_defs.svh
`ifndef TOUCH_CTRL_DEFS_SVH
`define TOUCH_CTRL_DEFS_SVH

// Register offsets
`define OFS_UNUSED      4'h0
`define OFS_CTRL1       4'h1
`define OFS_CTRL2       4'h2
`define OFS_CTRL3       4'h3
`define OFS_AB_HIGH     4'h4
`define OFS_AB_LOW      4'h5
`define OFS_TEMP_HIGH   4'h6
`define OFS_TEMP_LOW    4'h7
`define OFS_RES_FIRST   4'h8
`define OFS_RES_LAST    4'hd
`define OFS_ID          4'he

// Reset values
`define RST_ZERO        16'h0000
`define RST_CTRL2       16'h4040

// Control one fields
`define C1_INT_EN       15
`define C1_CHAN_HI      14
`define C1_CHAN_LO      12
`define C1_MODE_HI      11
`define C1_MODE_LO      10
`define C1_ACQ_HI       9
`define C1_ACQ_LO       8
`define C1_TMR_HI       7
`define C1_TMR_LO       0

// Control two fields
`define C2_PIN_EN       13
`define C2_PIN_DATA     12
`define C2_PIN_DIR      11
`define C2_PIN_POL      10
`define C2_MED_HI       6
`define C2_MED_LO       5
`define C2_FCD_HI       1
`define C2_FCD_LO       0

// Control three fields
`define C3_SEQ_HI       5
`define C3_SEQ_LO       0
`define C3_AB_HI_STAT   8
`define C3_AB_LO_STAT   9
`define C3_AB_HI_EN     10
`define C3_AB_LO_EN     11
`define C3_PIN_MASK     12
`define C3_TP_HI_STAT   13
`define C3_TP_LO_STAT   14
`define C3_TP_EN        15

// Channel select codes and master mode code
`define CH_X            3'h7
`define CH_Y            3'h6
`define CH_Z1           3'h5
`define CH_Z2           3'h4
`define CH_AUX          3'h3
`define CH_BAT          3'h2
`define CH_TEMP         3'h1
`define MODE_MASTER     2'h3

// Timing, times in ns, clock in MHz
`define CLK_MHZ         200
`define T_ACQ2_NS       2000
`define T_ACQ4_NS       4000
`define T_ACQ8_NS       8000
`define T_ACQ16_NS      16000
`define CONVERSION_TIME_NS       7500
`define T_SORT_NS       2000
`define ACQ2_CYC        ((`T_ACQ2_NS * `CLK_MHZ) / 1000)
`define ACQ4_CYC        ((`T_ACQ4_NS * `CLK_MHZ) / 1000)
`define ACQ8_CYC        ((`T_ACQ8_NS * `CLK_MHZ) / 1000)
`define ACQ16_CYC       ((`T_ACQ16_NS * `CLK_MHZ) / 1000)
`define CONV_CYC        ((`CONVERSION_TIME_NS * `CLK_MHZ) / 1000)
`define SORT_CYC        ((`T_SORT_NS * `CLK_MHZ) / 1000)

`endif

// >>> touch_ctrl_pkg.sv
package touch_ctrl_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_LEAD, S_PICK, S_SETTLE, S_MEAS, S_TAIL, S_TIMER
  } seq_state_t;
endpackage : touch_ctrl_pkg

// >>> conv_partner.sv
`timescale 1ns/10ps
module conv_partner #(
  parameter int LAG = 3
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        conv_start_in,
  input  wire logic [2:0]  conv_chan_in,
  input  wire logic        inj_in,
  input  wire logic [2:0]  inj_chan_in,
  input  wire logic [15:0] inj_data_in,
  output logic             res_valid_out,
  output logic      [2:0]  res_chan_out,
  output logic      [15:0] res_data_out
);
  int          wait_r;
  logic [2:0]  chan_r;
  logic [15:0] lfsr_r;

  always_ff @(posedge clk_in) begin
    res_valid_out <= 1'b0;
    res_data_out  <= ~res_data_out;
    if (!nrst_in) begin
      wait_r       <= 0;
      chan_r       <= 3'h0;
      res_chan_out <= 3'h0;
      res_data_out <= 16'h0000;
      lfsr_r       <= 16'h0ace;
    end else if (inj_in) begin
      res_valid_out <= 1'b1;
      res_chan_out  <= inj_chan_in;
      res_data_out  <= inj_data_in;
    end else if (conv_start_in) begin
      wait_r <= LAG;
      chan_r <= conv_chan_in;
    end else if (wait_r == 1) begin
      wait_r        <= 0;
      res_valid_out <= 1'b1;
      res_chan_out  <= chan_r;
      res_data_out  <= {4'h0, lfsr_r[11:0]};
      lfsr_r        <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13]};
    end else if (wait_r > 1) begin
      wait_r <= wait_r - 1;
    end
  end
endmodule : conv_partner

// >>> tb_touch_ctrl_limits_gpio_timing.sv
`timescale 1ns/10ps
module tb_touch_ctrl_limits_gpio_timing;
  logic        clk_in, nrst_in, reg_wr_in, res_valid_in, seq_start_in, pin_in, inj;
  logic        conv_start_out, seq_busy_out, pin_out, pin_oe_out, alarm_n_out;
  logic [3:0]  reg_addr_in;
  logic [2:0]  res_chan_in, conv_chan_out, inj_chan;
  logic [15:0] reg_wdata_in, reg_rdata_out, res_data_in, inj_data, rv, h, l, d, e;
  int          err_count, checked, seed, cyc;
  logic [1:0]  en;
  logic        ie, pol, dat;
  int          stamp[$];
  logic [2:0]  chs[$];

  touch_ctrl_limits_gpio_timing #(.PART_CODE(16'h1234), .FCD_UNIT_CYCLES(2), .TMR_UNIT_CYCLES(1)) dut_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .res_valid_in(res_valid_in),
    .res_chan_in(res_chan_in), .res_data_in(res_data_in), .seq_start_in(seq_start_in),
    .conv_start_out(conv_start_out), .conv_chan_out(conv_chan_out), .seq_busy_out(seq_busy_out),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out), .alarm_n_out(alarm_n_out));

  conv_partner #(.LAG(3)) model_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .conv_start_in(conv_start_out), .conv_chan_in(conv_chan_out),
    .inj_in(inj), .inj_chan_in(inj_chan), .inj_data_in(inj_data), .res_valid_out(res_valid_in),
    .res_chan_out(res_chan_in), .res_data_out(res_data_in));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic end_sim;
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    @(posedge clk_in);
    @(posedge clk_in);
    #1 v = reg_rdata_out;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : settle

  function automatic logic [15:0] reg_reset(input int a);
    return (a == 2) ? 16'h4040 : (a == 14) ? 16'h1234 : 16'h0000;
  endfunction : reg_reset

  // Start to start: acquisition, conversion, sort; one pick cycle at a channel change
  function automatic logic [15:0] gap_exp(input int i);
    return (i < 4) ? 16'(800 + 1500 + 400) : (i == 4) ? 16'(800 + 1500 + 400 + 1) : 16'(3200 + 1500 + 400);
  endfunction : gap_exp

  initial begin
    #250000;
    err_count++;
    end_sim();
  end

  initial begin
    {nrst_in, reg_wr_in, seq_start_in, pin_in, inj} = 5'b0;
    reg_addr_in = 4'h0; reg_wdata_in = 16'h0000; inj_chan = 3'h0; inj_data = 16'h0000;
    err_count = 0; checked = 0; seed = 61;
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], rv);
      chk("reset", reg_reset(a), rv);
    end
    wr(4'h8, 16'hffff); rd(4'h8, rv); chk("result_ro", 16'h0000, rv);
    wr(4'he, 16'hffff); rd(4'he, rv); chk("id_ro", 16'h1234, rv);
    wr(4'h0, 16'h5aa5); rd(4'h0, rv); chk("unused_rw", 16'h5aa5, rv);
    for (int i = 0; i < 24; i++) begin
      h = 16'($random(seed)) & 16'h0fff; l = 16'($random(seed)) & 16'h0fff;
      d = (i == 0) ? h : (i == 1) ? h + 1 : (i == 2) ? l : (i == 3) ? l - 1 : 16'($random(seed)) & 16'h0fff;
      en = (i < 4) ? 2'b11 : 2'($random(seed)); ie = (i < 4) ? 1'b1 : 1'($random(seed));
      wr(4'h4, h); wr(4'h5, l); wr(4'h1, {ie, 15'h0}); wr(4'h3, {4'h0, en, 10'h0});
      @(posedge clk_in);
      inj <= 1'b1; inj_data <= d; inj_chan <= (i % 2) ? 3'h3 : 3'h2;
      @(posedge clk_in);
      inj <= 1'b0;
      settle(3);
      e = {4'h0, en, (d < l), (d > h), 8'h0};
      rd(4'h3, rv); chk("limit_status", e, rv);
      chk("limit_alarm", {15'h0, ~(ie & |(en & {e[9], e[8]}))}, {15'h0, alarm_n_out});
    end
    wr(4'h3, 16'h0000); wr(4'h1, 16'h8000);
    for (int k = 0; k < 4; k++) begin
      {pol, dat} = k[1:0];
      wr(4'h2, {3'h0, dat, 2'b10, 10'h0}); settle(1);
      chk("pin_off", 16'h0001, {14'h0, pin_oe_out, alarm_n_out});
      wr(4'h2, {3'h1, dat, 1'b0, pol, 10'h0}); settle(1);
      chk("pin_drive", {14'h0, 1'b1, ~(pol ^ dat)}, {14'h0, pin_oe_out, pin_out});
      chk("out_no_alarm", 16'h0001, {15'h0, alarm_n_out});
      pin_in <= dat;
      wr(4'h2, {3'h1, 1'b0, 1'b1, pol, 10'h0}); settle(4);
      rd(4'h2, rv); chk("pin_in_data", {3'h1, ~(pol ^ dat), 1'b1, pol, 10'h0}, rv);
      chk("pin_alarm", {15'h0, pol ^ dat}, {15'h0, alarm_n_out});
      wr(4'h2, {3'h1, pol ^ dat, 1'b1, pol, 10'h0}); rd(4'h2, rv);
      chk("data_ro", {3'h1, ~(pol ^ dat), 1'b1, pol, 10'h0}, rv);
      wr(4'h3, 16'h1000); settle(1);
      chk("pin_mask", 16'h0001, {15'h0, alarm_n_out});
      wr(4'h3, 16'h0000); settle(1);
      chk("pin_stays", {15'h0, pol ^ dat}, {15'h0, alarm_n_out});
    end
    pin_in <= 1'b1; settle(4);
    chk("pin_set", 16'h0000, {15'h0, alarm_n_out});
    pin_in <= 1'b0; settle(4);
    chk("pin_clear", 16'h0001, {15'h0, alarm_n_out});
    wr(4'h2, 16'h0000);
    wr(4'h3, 16'h0030); wr(4'h1, 16'h3903); wr(4'h2, 16'h0021);
    @(posedge clk_in);
    seq_start_in <= 1'b1;
    @(posedge clk_in);
    seq_start_in <= 1'b0;
    cyc = 0;
    while (cyc < 40000 && (cyc < 3 || seq_busy_out === 1'b1)) begin
      @(posedge clk_in);
      #1 cyc++;
      if (conv_start_out === 1'b1) begin
        stamp.push_back(cyc);
        chs.push_back(conv_chan_out);
      end
    end
    chk("seq_done", 16'h0000, {15'h0, seq_busy_out});
    chk("conv_count", 16'd8, 16'(stamp.size()));
    for (int i = 0; i < stamp.size() && i < 8; i++) begin
      chk("conv_chan", (i < 4) ? 16'h3 : 16'h1, {13'h0, chs[i]});
      if (i > 0) chk("meas_gap", gap_exp(i), 16'(stamp[i] - stamp[i - 1]));
    end
    if (stamp.size() > 0) begin
      chk("tail_len", 16'(5100 + 1 + 4 + 3), 16'(cyc - stamp[stamp.size() - 1]));
    end
    end_sim();
  end
endmodule : tb_touch_ctrl_limits_gpio_timing
